// File: shared/rhpps_pkg.sv
`default_nettype none
package rhpps_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_PORT_STATUS = 12'h000;
  localparam logic [11:0] ADDR_PORT_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h00C;

  // ----------------------------------------------------------------
  // port status word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_CONNECT    = 0;
  localparam int BIT_ENABLE     = 1;
  localparam int BIT_SUSPEND    = 2;
  localparam int BIT_RESET      = 4;
  localparam int BIT_POWER      = 8;
  localparam int BIT_CLR_POWER  = 9;
  localparam int BIT_LOW_SPEED  = 9;
  localparam int BIT_CONN_CHG   = 16;

  // ----------------------------------------------------------------
  // port control word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_SWITCH_MODE = 0;
  localparam int BIT_POWER_MASK  = 1;
  localparam int BIT_SET_GLOBAL  = 2;
  localparam int BIT_CLR_GLOBAL  = 3;
  localparam int BIT_REMOVABLE   = 4;
  localparam int BIT_SW_SUPPORT  = 5;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_CONN_CHG  = 0;
  localparam int IRQ_POWER_OFF = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CTRL_RESET   = 6'h20;
  localparam logic [1:0] IRQ_RESET    = 2'h0;
  localparam logic       FLAG_RESET   = 1'b0;

  typedef enum logic [1:0] {
    BUS_ADDR = 2'b01,
    BUS_DATA = 2'b10
  } rhpps_bus_e;

endpackage : rhpps_pkg
`default_nettype wire

// File: rtl/rhpps_top.sv
// Implementation choices: the register offsets and the AHB-Lite slave port.
`default_nettype none
module rhpps_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // port side
  input  wire logic        overCurrent,
  input  wire logic        deviceConnected,
  input  wire logic        lowSpeedDevice,
  input  wire logic        rootHubReset,
  // port state outputs
  output logic             portPowerFlag,
  output logic             currentConnectFlag,
  output logic             portEnabledFlag,
  output logic             portSuspendedFlag,
  output logic             portResetActiveFlag,
  output logic             irq
);

  // ----------------------------------------------------------------
  // bus capture
  // ----------------------------------------------------------------
  logic        dataPhase;
  logic        dataWrite;
  logic [11:0] dataAddr;
  logic        addrValid;

  // address phase taken on a nonsequential or sequential selected transfer
  assign addrValid = hsel & hready & htrans[1];

  // latch address phase for use in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 12'h000;
    end else if (hready) begin
      dataPhase <= addrValid;
      dataWrite <= addrValid & hwrite;
      dataAddr  <= haddr[11:0];
    end
  end

  // always zero wait, okay response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  logic wrStatus;
  logic wrCtrl;
  logic wrIrqStatus;
  logic wrIrqMask;

  assign wrStatus    = dataWrite & (dataAddr == rhpps_pkg::ADDR_PORT_STATUS);
  assign wrCtrl      = dataWrite & (dataAddr == rhpps_pkg::ADDR_PORT_CTRL);
  assign wrIrqStatus = dataWrite & (dataAddr == rhpps_pkg::ADDR_IRQ_STATUS);
  assign wrIrqMask   = dataWrite & (dataAddr == rhpps_pkg::ADDR_IRQ_MASK);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic       powerSwitchMode;
  logic       perPortPowerMask;
  logic       deviceRemovableBit;
  logic       switchSupported;

  assign powerSwitchMode    = ctrl[rhpps_pkg::BIT_SWITCH_MODE];
  assign perPortPowerMask   = ctrl[rhpps_pkg::BIT_POWER_MASK];
  assign deviceRemovableBit = ctrl[rhpps_pkg::BIT_REMOVABLE];
  assign switchSupported    = ctrl[rhpps_pkg::BIT_SW_SUPPORT];

  // global command bits are self-clearing strobes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= rhpps_pkg::CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl <= hwdata[5:0];
    end else begin
      ctrl[rhpps_pkg::BIT_SET_GLOBAL] <= 1'b0;
      ctrl[rhpps_pkg::BIT_CLR_GLOBAL] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power command decode
  // ----------------------------------------------------------------
  logic setPortPowerCmd;
  logic clearPortPowerCmd;
  logic setGlobalPowerCmd;
  logic clearGlobalPowerCmd;
  logic perPortEnabled;
  logic doSetPower;
  logic doClearPower;

  // only ones written act as commands
  assign setPortPowerCmd     = wrStatus & hwdata[rhpps_pkg::BIT_POWER];
  assign clearPortPowerCmd   = wrStatus & hwdata[rhpps_pkg::BIT_CLR_POWER];
  assign setGlobalPowerCmd   = ctrl[rhpps_pkg::BIT_SET_GLOBAL];
  assign clearGlobalPowerCmd = ctrl[rhpps_pkg::BIT_CLR_GLOBAL];

  // per-port commands only in per-port mode with mask set
  assign perPortEnabled = powerSwitchMode & perPortPowerMask;
  assign doSetPower   = perPortEnabled ? setPortPowerCmd : setGlobalPowerCmd;
  assign doClearPower = perPortEnabled ? clearPortPowerCmd : clearGlobalPowerCmd;

  // ----------------------------------------------------------------
  // port power flag
  // ----------------------------------------------------------------
  logic powerState;
  logic next_powerState;

  // overcurrent and clear win over set
  always_comb begin
    next_powerState = powerState;
    if (doSetPower) begin
      next_powerState = 1'b1;
    end
    if (doClearPower) begin
      next_powerState = 1'b0;
    end
    if (overCurrent) begin
      next_powerState = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerState <= rhpps_pkg::FLAG_RESET;
    end else begin
      powerState <= next_powerState;
    end
  end

  // effective power: always on when switching is not built
  logic powerOn;
  assign powerOn = switchSupported ? powerState : 1'b1;

  // power fell this cycle
  logic powerPrev;
  logic powerOff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      powerPrev <= 1'b0;
    end else begin
      powerPrev <= powerOn;
    end
  end
  assign powerOff = powerPrev & ~powerOn;

  // ----------------------------------------------------------------
  // port status flags
  // ----------------------------------------------------------------
  logic setResetCmd;
  logic setEnableCmd;
  logic setSuspendCmd;
  logic connectRaw;

  assign setResetCmd   = wrStatus & hwdata[rhpps_pkg::BIT_RESET];
  assign setEnableCmd  = wrStatus & hwdata[rhpps_pkg::BIT_ENABLE];
  assign setSuspendCmd = wrStatus & hwdata[rhpps_pkg::BIT_SUSPEND];
  assign connectRaw    = deviceConnected & powerOn;

  // connect flag follows the port while powered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      currentConnectFlag <= 1'b0;
    end else begin
      currentConnectFlag <= connectRaw;
    end
  end

  // enable, suspend and reset only set while connected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      portEnabledFlag     <= 1'b0;
      portSuspendedFlag   <= 1'b0;
      portResetActiveFlag <= 1'b0;
    end else if (!powerOn || !connectRaw) begin
      portEnabledFlag     <= 1'b0;
      portSuspendedFlag   <= 1'b0;
      portResetActiveFlag <= 1'b0;
    end else begin
      if (setEnableCmd && currentConnectFlag) begin
        portEnabledFlag <= 1'b1;
      end
      if (setSuspendCmd && currentConnectFlag) begin
        portSuspendedFlag <= 1'b1;
      end
      if (setResetCmd && currentConnectFlag) begin
        portResetActiveFlag <= 1'b1;
      end
    end
  end

  // low speed indication sampled from the port
  logic lowSpeedAttached;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowSpeedAttached <= 1'b0;
    end else begin
      lowSpeedAttached <= lowSpeedDevice & connectRaw;
    end
  end

  // ----------------------------------------------------------------
  // connect change flag
  // ----------------------------------------------------------------
  logic connectChangeFlag;
  logic connectEvent;
  logic badCmdEvent;
  logic setChange;
  logic clrChange;

  assign connectEvent = (connectRaw != currentConnectFlag) & ~deviceRemovableBit;
  assign badCmdEvent  = ~currentConnectFlag & (setResetCmd | setEnableCmd | setSuspendCmd);
  assign setChange    = connectEvent | badCmdEvent | (deviceRemovableBit & rootHubReset);
  assign clrChange    = wrStatus & hwdata[rhpps_pkg::BIT_CONN_CHG];

  // set wins over a simultaneous clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      connectChangeFlag <= rhpps_pkg::FLAG_RESET;
    end else if (setChange) begin
      connectChangeFlag <= 1'b1;
    end else if (clrChange) begin
      connectChangeFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [1:0] irqEvents;

  assign irqEvents = {powerOff, setChange};

  // sticky, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= rhpps_pkg::IRQ_RESET;
    end else begin
      irqStatus <= irqEvents | (irqStatus & ~(wrIrqStatus ? hwdata[1:0] : 2'h0));
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= rhpps_pkg::IRQ_RESET;
    end else if (wrIrqMask) begin
      irqMask <= hwdata[1:0];
    end
  end

  // registered level interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq());
    end
  end

  function automatic logic [1:0] next_irq();
    next_irq = (irqEvents | (irqStatus & ~(wrIrqStatus ? hwdata[1:0] : 2'h0))) & irqMask;
  endfunction : next_irq

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] statusWord;
  logic [31:0] readMux;

  // reserved bits read as zero
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[rhpps_pkg::BIT_CONNECT]   = currentConnectFlag;
    statusWord[rhpps_pkg::BIT_ENABLE]    = portEnabledFlag;
    statusWord[rhpps_pkg::BIT_SUSPEND]   = portSuspendedFlag;
    statusWord[rhpps_pkg::BIT_RESET]     = portResetActiveFlag;
    statusWord[rhpps_pkg::BIT_POWER]     = powerOn;
    statusWord[rhpps_pkg::BIT_LOW_SPEED] = lowSpeedAttached;
    statusWord[rhpps_pkg::BIT_CONN_CHG]  = connectChangeFlag;
  end

  // decode on the address phase, register for the data phase
  always_comb begin
    readMux = 32'h0000_0000;
    case (haddr[11:0])
      rhpps_pkg::ADDR_PORT_STATUS: readMux = statusWord;
      rhpps_pkg::ADDR_PORT_CTRL:   readMux = {26'h000_0000, ctrl};
      rhpps_pkg::ADDR_IRQ_STATUS:  readMux = {30'h0000_0000, irqStatus};
      rhpps_pkg::ADDR_IRQ_MASK:    readMux = {30'h0000_0000, irqMask};
      default:                     readMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrValid && !hwrite) begin
      hrdata <= readMux;
    end
  end

  // ----------------------------------------------------------------
  // port state outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      portPowerFlag <= 1'b0;
    end else begin
      portPowerFlag <= next_powerState | ~switchSupported;
    end
  end

endmodule : rhpps_top
`default_nettype wire

// File: tb/rhpps_usb_dev.sv
`default_nettype none
module rhpps_usb_dev (
  // clock
  input wire logic ref_clk,
  // commands from the bench
  input wire logic plugIn,
  input wire logic wantLow,
  input wire logic shortOut,
  // port lines towards the hub
  output logic     deviceConnected,
  output logic     lowSpeedDevice,
  output logic     overCurrent
);
  timeunit 1ns;
  timeprecision 1ps;

  logic junk = 1'b0;

  // speed line carries no meaning while detached, so it wanders
  always @(posedge ref_clk) begin
    junk <= ~junk;
  end

  // attach, speed and fault lines
  assign deviceConnected = plugIn;
  assign lowSpeedDevice  = plugIn ? wantLow : junk;
  assign overCurrent     = shortOut;
endmodule : rhpps_usb_dev
`default_nettype wire

// File: tb/rhpps_assertions.sv
`default_nettype none
module rhpps_assertions (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // port
  input wire logic        deviceConnected,
  input wire logic        portPowerFlag,
  input wire logic        currentConnectFlag,
  input wire logic        portEnabledFlag,
  input wire logic        portSuspendedFlag,
  input wire logic        portResetActiveFlag,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // read address phase taken this edge
  logic rdTaken;
  assign rdTaken = hsel && htrans[1] && hready && !hwrite;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready_okay;
    hsel && htrans[1] && hready |=> hreadyout && !hresp;
  endproperty
  a_ready_okay: assert property (p_ready_okay) else $error("bus stalled or errored");
  property p_rdata_hold;
    $changed(hrdata) |-> $past(rdTaken);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
  property p_conn_on;
    (deviceConnected && portPowerFlag) [*3] |-> currentConnectFlag;
  endproperty
  a_conn_on: assert property (p_conn_on) else $error("connect flag missing");
  property p_conn_off;
    !deviceConnected [*3] |-> !currentConnectFlag;
  endproperty
  a_conn_off: assert property (p_conn_off) else $error("connect flag without device");
  property p_off_clear;
    !portPowerFlag [*3] |-> !currentConnectFlag && !portEnabledFlag && !portSuspendedFlag && !portResetActiveFlag;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("status kept while unpowered");
  property p_en_rise;
    $rose(portEnabledFlag) |-> $past(currentConnectFlag);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enabled while disconnected");
  property p_susp_rise;
    $rose(portSuspendedFlag) |-> $past(currentConnectFlag);
  endproperty
  a_susp_rise: assert property (p_susp_rise) else $error("suspended while disconnected");
  property p_rst_rise;
    $rose(portResetActiveFlag) |-> $past(currentConnectFlag);
  endproperty
  a_rst_rise: assert property (p_rst_rise) else $error("port reset while disconnected");

  // main scenarios
  c_power: cover property ($rose(portPowerFlag));
  c_conn: cover property ($rose(currentConnectFlag));
  c_irq: cover property ($rose(irq));
  c_en: cover property ($rose(portEnabledFlag));
endmodule : rhpps_assertions
`default_nettype wire

// File: tb/root_hub_port_power_status_bench.sv
`default_nettype none
module root_hub_port_power_status_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, irq;
  logic        plugIn = 1'b0, wantLow = 1'b0, shortOut = 1'b0, rootHubReset = 1'b0;
  logic        deviceConnected, lowSpeedDevice, overCurrent;
  logic        portPowerFlag, currentConnectFlag, portEnabledFlag, portSuspendedFlag, portResetActiveFlag;
  int          mismatches = 0;
  int          checks = 0;
  localparam logic [11:0] ST = rhpps_pkg::ADDR_PORT_STATUS;
  localparam logic [11:0] CT = rhpps_pkg::ADDR_PORT_CTRL;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;

  // clock
  always #2.5 ref_clk = ~ref_clk;

  rhpps_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .overCurrent(overCurrent), .deviceConnected(deviceConnected),
    .lowSpeedDevice(lowSpeedDevice), .rootHubReset(rootHubReset), .portPowerFlag(portPowerFlag),
    .currentConnectFlag(currentConnectFlag), .portEnabledFlag(portEnabledFlag),
    .portSuspendedFlag(portSuspendedFlag), .portResetActiveFlag(portResetActiveFlag), .irq(irq));
  rhpps_usb_dev i_dev (.ref_clk(ref_clk), .plugIn(plugIn), .wantLow(wantLow), .shortOut(shortOut),
    .deviceConnected(deviceConnected), .lowSpeedDevice(lowSpeedDevice), .overCurrent(overCurrent));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1; haddr <= {20'h0_0000, a}; htrans <= 2'h2; hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    q = hrdata;
    repeat (3) @(posedge ref_clk);
  endtask : bus
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, q & m, exp);
  endtask : rdc
  task automatic report_and_stop;
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (8000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc("ctrl reset", CT, ALL, 32'h0000_0020);
    rdc("status reset", ST, ALL, 32'h0000_0000);
    wr(12'h010, ALL);
    rdc("unmapped", 12'h010, ALL, 32'h0000_0000);
    wr(CT, 32'h0000_0024);
    rdc("global set", ST, ALL, 32'h0000_0100);
    chk("power pin on", {31'h0, portPowerFlag}, 32'h0000_0001);
    wr(ST, 32'h0000_0200);
    wr(ST, 32'h0000_0000);
    rdc("per-port in global mode", ST, ALL, 32'h0000_0100);
    wr(rhpps_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    plugIn <= 1'b1; wantLow <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc("attach low speed", ST, ALL, 32'h0001_0301);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    wr(ST, 32'h0000_FC00);
    rdc("reserved and zero write", ST, ALL, 32'h0001_0301);
    wr(ST, 32'h0001_0000);
    rdc("change cleared", ST, ALL, 32'h0000_0301);
    wr(rhpps_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(rhpps_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    rdc("irq cleared", rhpps_pkg::ADDR_IRQ_STATUS, ALL, 32'h0000_0000);
    wr(rhpps_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
    wr(ST, 32'h0000_0002);
    rdc("enable", ST, 32'h0000_0003, 32'h0000_0003);
    wr(ST, 32'h0000_0014);
    rdc("suspend and reset", ST, 32'h0001_0017, 32'h0000_0017);
    chk("suspend pin", {31'h0, portSuspendedFlag}, 32'h0000_0001);
    chk("reset pin", {31'h0, portResetActiveFlag}, 32'h0000_0001);
    wr(CT, 32'h0000_0023);
    wr(ST, 32'h0000_0200);
    rdc("per-port clear", ST, 32'h0000_01FF, 32'h0000_0000);
    chk("irq power off", {31'h0, irq}, 32'h0000_0001);
    wr(CT, 32'h0000_0027);
    rdc("global set masked off", ST, 32'h0000_0100, 32'h0000_0000);
    wr(ST, 32'h0000_0100);
    rdc("per-port set", ST, 32'h0000_0101, 32'h0000_0101);
    wr(CT, 32'h0000_0021);
    wr(ST, 32'h0000_0200);
    rdc("per-port unmasked ignored", ST, 32'h0000_0100, 32'h0000_0100);
    wr(CT, 32'h0000_0029);
    rdc("global clear unmasked", ST, 32'h0000_0100, 32'h0000_0000);
    wr(CT, 32'h0000_0024);
    shortOut <= 1'b1;
    repeat (3) @(posedge ref_clk);
    shortOut <= 1'b0;
    rdc("overcurrent", ST, 32'h0000_0100, 32'h0000_0000);
    chk("power pin off", {31'h0, portPowerFlag}, 32'h0000_0000);
    wr(CT, 32'h0000_0024);
    plugIn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 1; i <= 4; i++) begin
      if (i != 3) begin
        wr(ST, 32'h0001_0000);
        wr(ST, 32'h0000_0001 << i);
        rdc("write while detached", ST, 32'h0001_0017, 32'h0001_0000);
      end
    end
    wr(CT, 32'h0000_0034);
    wr(ST, 32'h0001_0000);
    plugIn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc("removable attach", ST, 32'h0001_0001, 32'h0000_0001);
    rootHubReset <= 1'b1;
    @(posedge ref_clk);
    rootHubReset <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rdc("removable after hub reset", ST, 32'h0001_0000, 32'h0001_0000);
    wr(CT, 32'h0000_0038);
    rdc("power off", ST, 32'h0000_0100, 32'h0000_0000);
    wr(CT, 32'h0000_0000);
    rdc("no switching", ST, 32'h0000_0100, 32'h0000_0100);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc("ctrl second reset", CT, ALL, 32'h0000_0020);
    rdc("status second reset", ST, 32'h0001_0101, 32'h0000_0000);
    report_and_stop();
  end
endmodule : root_hub_port_power_status_bench

bind rhpps_top rhpps_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .deviceConnected(deviceConnected), .portPowerFlag(portPowerFlag), .currentConnectFlag(currentConnectFlag),
  .portEnabledFlag(portEnabledFlag), .portSuspendedFlag(portSuspendedFlag),
  .portResetActiveFlag(portResetActiveFlag), .irq(irq));
`default_nettype wire
